// ==== src/lpsw_top.sv ====
// low-power switch sense configuration registers behind the serial link
`timescale 1ns/100ps
`include "lpsw_defines.svh"
module lpsw_top #(
   parameter int NPROG = `LPSW_NPROG,
   parameter int NGND = `LPSW_NGND
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic fault_status,
   input wire logic wake_event,
   input wire lpsw_pkg::lpsw_sw_t switch_state,
   input wire logic [NPROG-1:0] battery_switch_config,
   output logic sleep_mode,
   output logic interrupt_flag,
   output logic [NGND-1:0] gnd_comparator_only,
   output logic [NPROG-1:0] prog_use_delta,
   output logic [NGND-1:0] gnd_use_delta,
   output logic [NPROG-1:0] prog_poll_programmed,
   output logic [NPROG-1:0] prog_poll_default_high,
   output logic [NGND-1:0] gnd_poll_programmed
);
   import lpsw_pkg::*;

   // ***************************************************
   // link and crossings
   // ***************************************************
   lpsw_link_if link_bus ();

   lpsw_spi_link u_link (
      .sclk(sclk),
      .sys_rst(sys_rst),
      .cs_b(cs_b),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .link(link_bus.link)
   );

   logic tog_s;
   lpsw_sw_t sw_s;

   lpsw_sync #(.W(1)) u_tog_sync (
      .clk(ref_clk),
      .rst(sys_rst),
      .d(link_bus.rx_toggle),
      .q(tog_s)
   );

   lpsw_sync #(.W(`LPSW_NSW)) u_sw_sync (
      .clk(ref_clk),
      .rst(sys_rst),
      .d(switch_state),
      .q(sw_s)
   );

   // ***************************************************
   // decode helpers
   // ***************************************************
   function automatic logic hit(input lpsw_word_t w, input logic [7:0] ofs);
      hit = (w[`LPSW_ADDR_RANGE] == ofs[7:1]);
   endfunction

   function automatic logic is_sleep_cmd(input lpsw_word_t w);
      is_sleep_cmd = (w[`LPSW_TOP_RANGE] == `LPSW_OFS_SLEEP) &&
                     (w[`LPSW_DATA_RANGE] == `LPSW_SLEEP_DATA);
   endfunction

   // ***************************************************
   // register core
   // ***************************************************
   lpsw_word_t rx_w;
   logic frame_new;
   logic wr;
   logic tog_seen_q;
   logic tog_seen_d;
   logic [NGND-1:0] gcmp_q;
   logic [NGND-1:0] gcmp_d;
   logic [NPROG-1:0] pthr_q;
   logic [NPROG-1:0] pthr_d;
   logic [NGND-1:0] gthr_q;
   logic [NGND-1:0] gthr_d;
   logic [NPROG-1:0] ppoll_q;
   logic [NPROG-1:0] ppoll_d;
   logic [NGND-1:0] gpoll_q;
   logic [NGND-1:0] gpoll_d;
   lpsw_mode_t mode_q;
   lpsw_mode_t mode_d;
   logic int_q;
   logic int_d;
   lpsw_word_t tx_q;
   lpsw_word_t tx_d;
   logic [21:0] field;

   // the word was written a full sync delay before the toggle shows, so it is stable here
   assign rx_w = link_bus.rx_word;
   assign frame_new = tog_s ^ tog_seen_q;
   assign wr = rx_w[`LPSW_TYPE_BIT];
   // host must leave the core a few ref_clk cycles between frames before the next one
   assign link_bus.tx_word = tx_q;

   always_comb begin
      tog_seen_d = tog_s;
      gcmp_d = gcmp_q;
      pthr_d = pthr_q;
      gthr_d = gthr_q;
      ppoll_d = ppoll_q;
      gpoll_d = gpoll_q;
      mode_d = mode_q;
      int_d = int_q;
      tx_d = tx_q;
      field = `LPSW_FIELD_ZERO;
      if (frame_new) begin
         if (is_sleep_cmd(rx_w)) begin
            mode_d = LPSW_SLEEP; // [R7]
            tx_d = `LPSW_WORD_RST; // [R7]
         end else begin
            if (hit(rx_w, `LPSW_OFS_GCMP)) begin // [R10]
               if (wr) begin
                  gcmp_d = rx_w[NGND-1:0]; // [R1] [R14]
               end
               field = 22'(gcmp_d);
            end
            if (hit(rx_w, `LPSW_OFS_PTHR)) begin // [R12]
               if (wr) begin
                  pthr_d = rx_w[NPROG-1:0]; // [R14]
               end
               field = 22'(pthr_d);
            end
            if (hit(rx_w, `LPSW_OFS_GTHR)) begin // [R12]
               if (wr) begin
                  gthr_d = rx_w[NGND-1:0]; // [R14]
               end
               field = 22'(gthr_d);
            end
            if (hit(rx_w, `LPSW_OFS_PPOLL)) begin // [R13]
               if (wr) begin
                  ppoll_d = rx_w[NPROG-1:0]; // [R14]
               end
               field = 22'(ppoll_d);
            end
            if (hit(rx_w, `LPSW_OFS_GPOLL)) begin // [R13]
               if (wr) begin
                  gpoll_d = rx_w[NGND-1:0]; // [R14]
               end
               field = 22'(gpoll_d);
            end
            // unmapped addresses still echo the header and flags with zero data
            tx_d = {rx_w[`LPSW_TOP_RANGE], fault_status, int_q, field}; // [R10] [R11]
            // the flag is handed out in this response, so it is cleared here
            int_d = 1'b0;
         end
      end
      // wake comes after the clear so that a coinciding event is never lost
      if (wake_event && (mode_q == LPSW_SLEEP)) begin
         mode_d = LPSW_NORMAL;
         int_d = 1'b1; // [R9]
         tx_d = {`LPSW_OFS_STATUS, fault_status, 1'b1, sw_s}; // [R8] [R9]
      end
   end

   // sleep never touches the settings; only reset does
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tog_seen_q <= 1'b0;
         gcmp_q <= `LPSW_GND_RST; // [R1]
         pthr_q <= `LPSW_PROG_RST; // [R2]
         gthr_q <= `LPSW_GND_RST; // [R4]
         ppoll_q <= `LPSW_PROG_RST; // [R5]
         gpoll_q <= `LPSW_GND_RST; // [R6]
         mode_q <= LPSW_NORMAL;
         int_q <= `LPSW_INT_RST;
         tx_q <= `LPSW_WORD_RST;
      end else begin
         tog_seen_q <= tog_seen_d;
         gcmp_q <= gcmp_d;
         pthr_q <= pthr_d;
         gthr_q <= gthr_d;
         ppoll_q <= ppoll_d;
         gpoll_q <= gpoll_d;
         mode_q <= mode_d;
         int_q <= int_d;
         tx_q <= tx_d;
      end
   end

   // ***************************************************
   // sensing controls to the analog front end
   // ***************************************************
   logic [NGND-1:0] cmp_o_d;
   logic [NPROG-1:0] pdelta_o_d;
   logic [NGND-1:0] gdelta_o_d;
   logic [NPROG-1:0] ppoll_o_d;
   logic [NPROG-1:0] phigh_o_d;
   logic [NGND-1:0] gpoll_o_d;

   always_comb begin
      cmp_o_d = gcmp_q; // [R1]
      // a battery-switch channel cannot use the delta threshold at all
      pdelta_o_d = ~pthr_q & ~battery_switch_config; // [R2] [R3]
      gdelta_o_d = ~gthr_q; // [R4]
      ppoll_o_d = ppoll_q; // [R5]
      phigh_o_d = ~ppoll_q & battery_switch_config; // [R5]
      gpoll_o_d = gpoll_q; // [R6]
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gnd_comparator_only <= '0;
         prog_use_delta <= '0;
         gnd_use_delta <= '0;
         prog_poll_programmed <= '0;
         prog_poll_default_high <= '0;
         gnd_poll_programmed <= '0;
      end else begin
         gnd_comparator_only <= cmp_o_d;
         prog_use_delta <= pdelta_o_d;
         gnd_use_delta <= gdelta_o_d;
         prog_poll_programmed <= ppoll_o_d;
         prog_poll_default_high <= phigh_o_d;
         gnd_poll_programmed <= gpoll_o_d;
      end
   end

   assign sleep_mode = (mode_q == LPSW_SLEEP);
   assign interrupt_flag = int_q;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_write(logic [7:0] ofs);
      frame_new && wr && (rx_w[`LPSW_ADDR_RANGE] == ofs[7:1]);
   endsequence

   sequence s_wake;
      wake_event && (mode_q == LPSW_SLEEP);
   endsequence

   sequence s_cfg_frame;
      frame_new && !is_sleep_cmd(rx_w);
   endsequence

   a_gcmp_write: assert property ( // [R1]
      s_write(`LPSW_OFS_GCMP) |=> ##1 gnd_comparator_only == $past(rx_w[NGND-1:0], 2)
   ) else $error("ground comparator-only write not applied");

   a_pthr_battery: assert property ( // [R3]
      ##1 ((prog_use_delta & $past(battery_switch_config)) == '0)
   ) else $error("battery-switch channel given delta threshold");

   a_pthr_write: assert property ( // [R2]
      s_write(`LPSW_OFS_PTHR) ##1 (battery_switch_config == '0)
      |=> prog_use_delta == ~$past(rx_w[NPROG-1:0], 2)
   ) else $error("programmable threshold select wrong");

   a_gthr_write: assert property ( // [R4]
      s_write(`LPSW_OFS_GTHR) |=> ##1 gnd_use_delta == ~$past(rx_w[NGND-1:0], 2)
   ) else $error("ground threshold select wrong");

   a_ppoll_high: assert property ( // [R5]
      s_write(`LPSW_OFS_PPOLL) ##1 !$changed(battery_switch_config)
      |=> prog_poll_default_high ==
          (~$past(rx_w[NPROG-1:0], 2) & $past(battery_switch_config))
   ) else $error("programmable default polling current wrong");

   a_gpoll_write: assert property ( // [R6]
      s_write(`LPSW_OFS_GPOLL) |=> ##1 gnd_poll_programmed == $past(rx_w[NGND-1:0], 2)
   ) else $error("ground polling current select wrong");

   a_sleep_entry: assert property ( // [R7]
      frame_new && is_sleep_cmd(rx_w) && !wake_event
      |=> sleep_mode && (tx_q == `LPSW_WORD_RST) && $stable(int_q)
   ) else $error("sleep command not honoured");

   a_wake_keeps: assert property ( // [R8]
      (s_wake and !frame_new) |=> $stable(gcmp_q) && $stable(pthr_q) && $stable(gthr_q)
      && $stable(ppoll_q) && $stable(gpoll_q) && tx_q[`LPSW_FAULT_BIT] == $past(fault_status)
   ) else $error("settings or fault lost over sleep");

   a_wake_report: assert property ( // [R9]
      s_wake |=> interrupt_flag && !sleep_mode && tx_q[21:0] == $past(sw_s)
      && tx_q[`LPSW_TOP_RANGE] == `LPSW_OFS_STATUS
   ) else $error("wake did not report switch states");

   a_echo_header: assert property ( // [R10]
      (s_cfg_frame and !wake_event)
      |=> tx_q[`LPSW_TOP_RANGE] == $past(rx_w[`LPSW_TOP_RANGE])
   ) else $error("response header not echoed");

   a_flag_bits: assert property ( // [R11]
      (s_cfg_frame and (!wake_event && !int_q)) ##1 !wake_event
      |-> tx_q[`LPSW_FAULT_BIT] == $past(fault_status) && !tx_q[`LPSW_INT_BIT] && !int_q
   ) else $error("status flags in response wrong");

   a_reserved_zero: assert property ( // [R11]
      (s_cfg_frame and (!wake_event && hit(rx_w, `LPSW_OFS_PTHR)))
      |=> tx_q[21:NPROG] == '0 && tx_q[NPROG-1:0] == pthr_q
   ) else $error("reserved response bits not zero");

   a_read_still: assert property ( // [R14]
      (s_cfg_frame and !wr) |=> $stable(gcmp_q) && $stable(pthr_q) && $stable(gthr_q)
      && $stable(ppoll_q) && $stable(gpoll_q)
   ) else $error("read changed a register");

   a_poll_decode: assert property ( // [R13]
      (s_cfg_frame and (!wake_event && hit(rx_w, `LPSW_OFS_GPOLL)))
      |=> tx_q[NGND-1:0] == gpoll_q
   ) else $error("ground polling register not returned");

   a_thr_decode: assert property ( // [R12]
      (s_cfg_frame and (!wake_event && hit(rx_w, `LPSW_OFS_GTHR)))
      |=> tx_q[NGND-1:0] == gthr_q
   ) else $error("ground threshold register not returned");
endmodule

// ==== src/lpsw_defines.svh ====
// constants for the low-power switch sense configuration block
// What this block does
// R1 - ground comparator-only bits, reset zero
// R2 - programmable threshold bit clear adds delta threshold
// R3 - battery-switch programmable channels use normal threshold only
// R4 - ground threshold bit clear adds delta threshold
// R5 - programmable poll bit picks default or programmed current
// R6 - ground poll bit picks default or programmed current
// R7 - all-zero sleep command enters sleep, never readable
// R8 - settings survive sleep, fault reported after wake
// R9 - wake sets interrupt flag, returns all switch states
// R10 - response echoes address and type bits
// R11 - bit 23 fault, bit 22 interrupt, reserved zero
// R12 - threshold registers decoded at their addresses
// R13 - polling-current registers decoded at their addresses
// R14 - type bit set writes, clear reads without change
`ifndef LPSW_DEFINES_SVH
`define LPSW_DEFINES_SVH

`define LPSW_FRAME_BITS 6'd32
`define LPSW_LAST_BIT 6'd31
`define LPSW_CNT_ZERO 6'd0
`define LPSW_CNT_STEP 6'd1
`define LPSW_TOP_RANGE 31:24
`define LPSW_ADDR_RANGE 31:25
`define LPSW_DATA_RANGE 23:0
`define LPSW_TYPE_BIT 24
`define LPSW_FAULT_BIT 23
`define LPSW_INT_BIT 22
`define LPSW_NPROG 8
`define LPSW_NGND 14
`define LPSW_NSW 22

// printed offsets are {address, type}; bit 0 is the type bit
`define LPSW_OFS_GCMP 8'h26
`define LPSW_OFS_PTHR 8'h28
`define LPSW_OFS_GTHR 8'h2a
`define LPSW_OFS_PPOLL 8'h2c
`define LPSW_OFS_GPOLL 8'h2e
`define LPSW_OFS_SLEEP 8'h39
`define LPSW_OFS_STATUS 8'h3e
`define LPSW_SLEEP_DATA 24'h000000

`define LPSW_PROG_RST 8'h00
`define LPSW_GND_RST 14'h0000
`define LPSW_FIELD_ZERO 22'h000000
`define LPSW_WORD_RST 32'h00000000
`define LPSW_INT_RST 1'b1

`endif

// ==== src/lpsw_pkg.sv ====
// types shared by the low-power switch sense configuration block
package lpsw_pkg;
   typedef logic [31:0] lpsw_word_t;
   typedef logic [21:0] lpsw_sw_t;
   typedef enum logic {LPSW_NORMAL, LPSW_SLEEP} lpsw_mode_t;
endpackage

// ==== src/lpsw_link_if.sv ====
// carrier between the serial link logic and the register core
`timescale 1ns/100ps
interface lpsw_link_if;
   logic [31:0] rx_word;
   logic rx_toggle;
   logic [31:0] tx_word;
   modport link (output rx_word, output rx_toggle, input tx_word);
   modport core (input rx_word, input rx_toggle, output tx_word);
endinterface

// ==== src/lpsw_sync.sv ====
// two-flop level synchroniser, any width
`timescale 1ns/100ps
module lpsw_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule

// ==== src/lpsw_spi_link.sv ====
// serial link end: 32-bit frames on the link clock
`timescale 1ns/100ps
`include "lpsw_defines.svh"
module lpsw_spi_link (
   input wire logic sclk,
   input wire logic sys_rst,
   input wire logic cs_b,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   lpsw_link_if.link link
);
   import lpsw_pkg::*;

   logic [5:0] bit_cnt_q;
   logic [5:0] bit_cnt_d;
   logic [30:0] shift_in_q;
   logic [30:0] shift_in_d;
   logic [31:0] shift_out_q;
   logic [31:0] shift_out_d;
   lpsw_word_t rx_word_q;
   lpsw_word_t rx_word_d;
   logic rx_tog_q;
   logic rx_tog_d;
   logic frame_clr;

   // the link clock stops between frames, so the frame signal itself ends the frame
   assign frame_clr = cs_b | sys_rst;
   assign miso_oe = ~cs_b;
   // first bit must stand before the first edge, so it comes straight from the core word
   assign miso = (bit_cnt_q == `LPSW_CNT_ZERO) ? link.tx_word[31] : shift_out_q[31];
   assign link.rx_word = rx_word_q;
   assign link.rx_toggle = rx_tog_q;

   always_comb begin
      bit_cnt_d = bit_cnt_q;
      shift_in_d = {shift_in_q[29:0], mosi};
      shift_out_d = {shift_out_q[30:0], 1'b0};
      rx_word_d = rx_word_q;
      rx_tog_d = rx_tog_q;
      if (bit_cnt_q == `LPSW_CNT_ZERO) begin
         shift_out_d = {link.tx_word[30:0], 1'b0};
      end
      // extra bits beyond 32 are ignored; short frames never reach the core
      if (bit_cnt_q < `LPSW_FRAME_BITS) begin
         bit_cnt_d = bit_cnt_q + `LPSW_CNT_STEP;
      end
      if (bit_cnt_q == `LPSW_LAST_BIT) begin
         rx_word_d = {shift_in_q, mosi};
         rx_tog_d = ~rx_tog_q;
      end
   end

   always_ff @(posedge sclk or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_q <= `LPSW_CNT_ZERO;
         shift_in_q <= '0;
         shift_out_q <= '0;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         shift_in_q <= shift_in_d;
         shift_out_q <= shift_out_d;
      end
   end

   always_ff @(posedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_word_q <= `LPSW_WORD_RST;
         rx_tog_q <= 1'b0;
      end else begin
         rx_word_q <= rx_word_d;
         rx_tog_q <= rx_tog_d;
      end
   end
endmodule

// ==== test/lpsw_host_model.sv ====
// host model: serial master that drives whole 32-bit frames on the link clock
`timescale 1ns/100ps
module lpsw_host_model #(
   parameter real HALF_NS = 7.5
) (
   output logic sclk,
   output logic cs_b,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   // ****************************************
   // frame engine
   // ****************************************
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      mosi = 1'b0;
   end

   // link clock stands still low outside frames; slow stretches each low phase
   task automatic xfer(input logic [31:0] tx, input int slow, output logic [31:0] rx);
      cs_b = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i]; // msb first, type bit in bit 24
         #(HALF_NS * (1 + slow));
         rx[i] = miso_oe ? miso : 1'bx;
         sclk = 1'b1;
         #(HALF_NS);
         sclk = 1'b0;
      end
      #(HALF_NS);
      cs_b = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
   endtask
endmodule

// ==== test/low_power_switch_sense_config_tb_top.sv ====
// self-checking bench for the low-power switch sense configuration block
`timescale 1ns/100ps
module low_power_switch_sense_config_tb_top;
   import lpsw_pkg::*;
   logic ref_clk, sys_rst, sclk, cs_b, mosi, miso, miso_oe, fault_status, wake_event;
   lpsw_sw_t switch_state;
   logic [7:0] batt;
   logic sleep_mode, interrupt_flag;
   logic [13:0] gcmp, guse, gpoll;
   logic [7:0] puse, ppoll, phigh;
   int fails, samples_checked, cycles;
   logic [13:0] regs [5];
   logic [7:0] ofs [5] = '{8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e};
   logic [13:0] msk [5] = '{14'h3fff, 14'h00ff, 14'h3fff, 14'h00ff, 14'h3fff};
   logic exp_int, exp_sleep;
   logic [31:0] exp_resp;

   // ****************************************
   // clock, design and host
   // ****************************************
   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   lpsw_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_b(cs_b),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .fault_status(fault_status),
      .wake_event(wake_event), .switch_state(switch_state),
      .battery_switch_config(batt), .sleep_mode(sleep_mode),
      .interrupt_flag(interrupt_flag), .gnd_comparator_only(gcmp),
      .prog_use_delta(puse), .gnd_use_delta(guse), .prog_poll_programmed(ppoll),
      .prog_poll_default_high(phigh), .gnd_poll_programmed(gpoll));

   lpsw_host_model host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe));

   // ****************************************
   // checking helpers
   // ****************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic check_outs();
      check(32'(gcmp), 32'(regs[0]));
      check(32'(puse), {24'h000000, ~regs[1][7:0] & ~batt});
      check(32'(guse), {18'h00000, ~regs[2]});
      check(32'(ppoll), 32'(regs[3][7:0]));
      check(32'(phigh), 32'(~regs[3][7:0] & batt));
      check(32'(gpoll), 32'(regs[4]));
   endtask

   // one frame; its answer carries the response built for the previous frame
   task automatic frame(input logic [31:0] w, input int slow);
      logic [31:0] rx;
      logic [31:0] nxt;
      int k;
      host.xfer(w, slow, rx);
      check(rx, exp_resp);
      k = -1;
      for (int i = 0; i < 5; i++) begin
         if (w[31:25] == ofs[i][7:1]) k = i;
      end
      nxt = {w[31:24], fault_status, exp_int, 22'h000000};
      if (w == 32'h39000000) begin
         nxt = 32'h00000000;
         exp_sleep = 1'b1;
      end else begin
         if (k >= 0) begin
            if (w[24]) regs[k] = w[13:0] & msk[k];
            nxt[13:0] = regs[k];
         end
         exp_int = 1'b0;
      end
      exp_resp = nxt;
      // gap well above the minimum spacing between frames
      repeat (8) @(negedge ref_clk);
      check(32'(sleep_mode), 32'(exp_sleep));
      check(32'(interrupt_flag), 32'(exp_int));
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      sys_rst = 1'b1;
      fault_status = 1'b0;
      wake_event = 1'b0;
      switch_state = 22'h2b3c5d;
      batt = 8'h00;
      for (int i = 0; i < 5; i++) regs[i] = 14'h0000;
      exp_int = 1'b1;
      exp_sleep = 1'b0;
      exp_resp = 32'h00000000;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      check_outs();
      check(32'(interrupt_flag), 32'h1);
      check(32'(sleep_mode), 32'h0);
      // all ones with reserved bits set, then an alternating pattern
      for (int p = 0; p < 2; p++) begin
         fault_status = p[0];
         // first pass has no battery-switch channels, so every threshold bit is seen
         batt = p[0] ? 8'h5a : 8'h00;
         for (int i = 0; i < 5; i++) begin
            frame({ofs[i] | 8'h01, p ? 24'h152a55 : 24'hffffff}, 0);
            check_outs();
            frame({ofs[i], 24'h000000}, p);
         end
      end
      // unmapped address and a sleep command with nonzero data
      frame(32'h7a123456, 0);
      frame(32'h39000001, 0);
      // wake pulse while awake must do nothing
      wake_event = 1'b1;
      @(negedge ref_clk);
      wake_event = 1'b0;
      repeat (2) @(negedge ref_clk);
      check(32'(interrupt_flag), 32'h0);
      check(32'(sleep_mode), 32'h0);
      batt = 8'hc3;
      repeat (2) @(negedge ref_clk);
      check_outs();
      fault_status = 1'b0;
      frame(32'h39000000, 0);
      frame({8'h28, 24'h000000}, 0);
      fault_status = 1'b1;
      wake_event = 1'b1;
      @(negedge ref_clk);
      wake_event = 1'b0;
      repeat (2) @(negedge ref_clk);
      exp_sleep = 1'b0;
      exp_int = 1'b1;
      exp_resp = {8'h3e, 1'b1, 1'b1, switch_state};
      check(32'(sleep_mode), 32'h0);
      check(32'(interrupt_flag), 32'h1);
      check_outs();
      frame({8'h2e, 24'h000000}, 0);
      frame({8'h26, 24'h000000}, 0);
      print_verdict();
   end
endmodule
